// ==== verilog/pcf_top.sv ====
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pcf_params.svh"
module pcf_top (
  input wire logic pclk, // APB clock, 50 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire pcf_pkg::pcf_meas_type meas, // Measurement update.
  input wire logic signed [15:0] thermistor_sense_pin, // External thermistor reading.
  input wire logic ra_stop_req, // Request to stop resistance updates.
  input wire logic [7:0] res_factor_limit, // Max or min factor to ramp to.
  output logic [7:0] res_factor, // Present resistance factor.
  output logic ra_updates_stopped, // Resistance updates stopped.
  output logic calibration_mode, // Calibration mode active.
  output logic charge_term_pulse, // One-cycle pulse on charge termination.
  output var pcf_pkg::pcf_flags_type flags // Status flags.
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [15:0] setup_q, setup_d;
  logic [31:0] chg_heat_q, chg_heat_d;
  logic [31:0] dsg_heat_q, dsg_heat_d;
  logic [31:0] persist_q, persist_d;
  logic [31:0] flow_q, flow_d;
  logic [31:0] target_q, target_d;
  logic [31:0] term_q, term_d;
  logic [15:0] full_cap_q, full_cap_d;
  logic [15:0] left_cap_q, left_cap_d;
  logic cal_req_q, cal_req_d;
  logic [31:0] prdata_q, prdata_d;
  logic wr_en, rd_setup, hit;
  logic term_now;
  logic signed [15:0] temp_sel;
  pcf_pkg::pcf_flags_type flags_q, flags_d;

  // Selected temperature source.
  assign temp_sel = setup_q[`PCF_BIT_EXT_SENSOR] ? thermistor_sense_pin : meas.int_temp;

  // Address decode and bus handshake; the slave never inserts wait states.
  always_comb begin
    hit = 1'b1;
    if (paddr == `PCF_OFS_SETUP) begin
      hit = 1'b1;
    end else if (paddr == `PCF_OFS_STATUS || paddr == `PCF_OFS_CHG_HEAT) begin
      hit = 1'b1;
    end else if (paddr == `PCF_OFS_DSG_HEAT || paddr == `PCF_OFS_PERSIST) begin
      hit = 1'b1;
    end else if (paddr == `PCF_OFS_FLOW || paddr == `PCF_OFS_TARGET) begin
      hit = 1'b1;
    end else if (paddr == `PCF_OFS_TERM || paddr == `PCF_OFS_FULL_CAP) begin
      hit = 1'b1;
    end else if (paddr == `PCF_OFS_LEFT_CAP || paddr == `PCF_OFS_CONTROL) begin
      hit = 1'b1;
    end else if (paddr == `PCF_OFS_TEMP) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end
  assign wr_en = psel && penable && pwrite && hit;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_q;

  // ----------------------------------------------------------------------
  // Register writes and read data
  // ----------------------------------------------------------------------
  // Next register values; a termination load of left capacity beats a write.
  always_comb begin
    setup_d = setup_q;
    chg_heat_d = chg_heat_q;
    dsg_heat_d = dsg_heat_q;
    persist_d = persist_q;
    flow_d = flow_q;
    target_d = target_q;
    term_d = term_q;
    full_cap_d = full_cap_q;
    left_cap_d = left_cap_q;
    cal_req_d = cal_req_q;
    prdata_d = prdata_q;
    if (wr_en) begin
      if (paddr == `PCF_OFS_SETUP) begin
        setup_d = pwdata[15:0] & `PCF_SETUP_WMASK;
      end else if (paddr == `PCF_OFS_CHG_HEAT) begin
        chg_heat_d = pwdata;
      end else if (paddr == `PCF_OFS_DSG_HEAT) begin
        dsg_heat_d = pwdata;
      end else if (paddr == `PCF_OFS_PERSIST) begin
        persist_d = pwdata;
      end else if (paddr == `PCF_OFS_FLOW) begin
        flow_d = pwdata;
      end else if (paddr == `PCF_OFS_TARGET) begin
        target_d = pwdata;
      end else if (paddr == `PCF_OFS_TERM) begin
        term_d = pwdata;
      end else if (paddr == `PCF_OFS_FULL_CAP) begin
        full_cap_d = pwdata[15:0];
      end else if (paddr == `PCF_OFS_LEFT_CAP) begin
        left_cap_d = pwdata[15:0];
      end else if (paddr == `PCF_OFS_CONTROL) begin
        cal_req_d = pwdata[0];
      end
    end
    if (term_now && setup_q[`PCF_BIT_FULL_ON_TERM]) begin
      left_cap_d = full_cap_q;
    end
    if (rd_setup) begin
      if (paddr == `PCF_OFS_SETUP) begin
        prdata_d = {16'h0000, setup_q};
      end else if (paddr == `PCF_OFS_STATUS) begin
        prdata_d = {16'h0000, flags_q.charge_overheat_flag, flags_q.discharge_overheat_flag,
                    10'h000, calibration_mode, ra_updates_stopped, flags_q.term_seen,
                    flags_q.charge_allowed_flag};
      end else if (paddr == `PCF_OFS_CHG_HEAT) begin
        prdata_d = chg_heat_q;
      end else if (paddr == `PCF_OFS_DSG_HEAT) begin
        prdata_d = dsg_heat_q;
      end else if (paddr == `PCF_OFS_PERSIST) begin
        prdata_d = persist_q;
      end else if (paddr == `PCF_OFS_FLOW) begin
        prdata_d = flow_q;
      end else if (paddr == `PCF_OFS_TARGET) begin
        prdata_d = target_q;
      end else if (paddr == `PCF_OFS_TERM) begin
        prdata_d = term_q;
      end else if (paddr == `PCF_OFS_FULL_CAP) begin
        prdata_d = {16'h0000, full_cap_q};
      end else if (paddr == `PCF_OFS_LEFT_CAP) begin
        prdata_d = {16'h0000, left_cap_q};
      end else if (paddr == `PCF_OFS_CONTROL) begin
        prdata_d = {31'h0000_0000, cal_req_q};
      end else if (paddr == `PCF_OFS_TEMP) begin
        prdata_d = {16'h0000, temp_sel};
      end else begin
        prdata_d = 32'h0000_0000;
      end
    end
  end

  // Register bank flip-flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_q <= `PCF_SETUP_RESET;
      chg_heat_q <= `PCF_CHG_HEAT_RESET;
      dsg_heat_q <= `PCF_DSG_HEAT_RESET;
      persist_q <= `PCF_PERSIST_RESET;
      flow_q <= `PCF_FLOW_RESET;
      target_q <= {16'h0000, `PCF_TARGET_MV_RESET};
      term_q <= `PCF_TERM_RESET;
      full_cap_q <= 16'h0000;
      left_cap_q <= 16'h0000;
      cal_req_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      setup_q <= setup_d;
      chg_heat_q <= chg_heat_d;
      dsg_heat_q <= dsg_heat_d;
      persist_q <= persist_d;
      flow_q <= flow_d;
      target_q <= target_d;
      term_q <= term_d;
      full_cap_q <= full_cap_d;
      left_cap_q <= left_cap_d;
      cal_req_q <= cal_req_d;
      prdata_q <= prdata_d;
    end
  end

  // Calibration mode is gated by the permission bit.
  assign calibration_mode = cal_req_q && setup_q[`PCF_BIT_CAL_ALLOW];

  // ----------------------------------------------------------------------
  // Overheat persistence, channel 0 charge and channel 1 discharge
  // ----------------------------------------------------------------------
  logic [1:0] hot, set_ok, release_ok;
  logic [15:0] cnt_q [2];
  logic [15:0] cnt_d [2];
  logic signed [15:0] lim [2];
  logic signed [15:0] rel [2];
  logic [15:0] per [2];
  logic chg_dir, dsg_dir;

  // Direction tests against the flow levels.
  assign chg_dir = meas.mean_current > $signed(flow_q[15:0]);
  assign dsg_dir = meas.mean_current <= -$signed(flow_q[31:16]);
  assign lim[0] = chg_heat_q[15:0];
  assign rel[0] = chg_heat_q[31:16];
  assign per[0] = persist_q[15:0];
  assign lim[1] = dsg_heat_q[15:0];
  assign rel[1] = dsg_heat_q[31:16];
  assign per[1] = persist_q[31:16];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_heat
      // Persist counter restarts on any measurement update where the hot condition fails.
      always_comb begin
        hot[ch] = (temp_sel >= lim[ch]) && ((ch == 0) ? chg_dir : dsg_dir);
        cnt_d[ch] = cnt_q[ch];
        if (meas.valid) begin
          cnt_d[ch] = hot[ch] ? ((cnt_q[ch] == 16'hFFFF) ? cnt_q[ch] : cnt_q[ch] + 16'h0001)
                              : 16'h0000;
        end
        set_ok[ch] = meas.valid && hot[ch] && (per[ch] != 16'h0000)
                     && (cnt_d[ch] >= per[ch]);
        release_ok[ch] = meas.valid && (temp_sel <= rel[ch]);
      end

      // Persist counter register.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q[ch] <= 16'h0000;
        end else begin
          cnt_q[ch] <= cnt_d[ch];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Charge termination detection
  // ----------------------------------------------------------------------
  logic [15:0] win_cnt_q, win_cnt_d;
  logic [15:0] cap_sum_q, cap_sum_d;
  logic all_low_q, all_low_d;
  logic [1:0] good_q, good_d;
  logic [15:0] cap_next;
  logic win_end, win_good, volts_ok;

  // Interval tracking, one step per measurement update.
  always_comb begin
    cap_next = cap_sum_q + meas.cap_delta;
    volts_ok = meas.stack_volts > (target_q[15:0] - target_q[31:16]);
    win_end = meas.valid && (win_cnt_q + 16'h0001 >= term_q[31:16]);
    win_good = all_low_q && (meas.mean_current < $signed(term_q[15:0]))
               && (cap_next > `PCF_TERM_CAP_MIN) && volts_ok;
    win_cnt_d = win_cnt_q;
    cap_sum_d = cap_sum_q;
    all_low_d = all_low_q;
    good_d = good_q;
    term_now = 1'b0;
    if (meas.valid) begin
      if (win_end) begin
        win_cnt_d = 16'h0000;
        cap_sum_d = 16'h0000;
        all_low_d = 1'b1;
        good_d = win_good ? ((good_q == 2'h0) ? 2'h1 : 2'h2) : 2'h0;
        term_now = win_good && (good_q != 2'h0) && flags_q.charge_allowed_flag;
      end else begin
        win_cnt_d = win_cnt_q + 16'h0001;
        cap_sum_d = (cap_next < cap_sum_q) ? 16'hFFFF : cap_next;
        all_low_d = all_low_q && (meas.mean_current < $signed(term_q[15:0]));
      end
    end
  end

  // Flags next values; hardware set and clear never collide with software.
  always_comb begin
    flags_d = flags_q;
    if (set_ok[0]) begin
      flags_d.charge_overheat_flag = 1'b1;
    end else if (release_ok[0]) begin
      flags_d.charge_overheat_flag = 1'b0;
    end
    if (set_ok[1]) begin
      flags_d.discharge_overheat_flag = 1'b1;
    end else if (release_ok[1]) begin
      flags_d.discharge_overheat_flag = 1'b0;
    end
    if (term_now) begin
      flags_d.charge_allowed_flag = 1'b0;
      flags_d.term_seen = 1'b1;
    end else if (meas.valid && dsg_dir) begin
      flags_d.charge_allowed_flag = 1'b1;
      flags_d.term_seen = 1'b0;
    end
  end

  // Termination and flag registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_q <= 16'h0000;
      cap_sum_q <= 16'h0000;
      all_low_q <= 1'b1;
      good_q <= 2'h0;
      flags_q <= 4'h1;
    end else begin
      win_cnt_q <= win_cnt_d;
      cap_sum_q <= cap_sum_d;
      all_low_q <= all_low_d;
      good_q <= good_d;
      flags_q <= flags_d;
    end
  end
  assign flags = flags_q;

  // ----------------------------------------------------------------------
  // Resistance factor ramp
  // ----------------------------------------------------------------------
  logic [7:0] res_q, res_d;
  logic at_limit;

  // Steps one count per update toward the limit before updates stop.
  always_comb begin
    at_limit = (res_q == res_factor_limit);
    res_d = res_q;
    if (meas.valid && ra_stop_req && setup_q[`PCF_BIT_RAMP_EN] && !at_limit) begin
      res_d = (res_q < res_factor_limit) ? res_q + 8'h01 : res_q - 8'h01;
    end
  end

  // Ramp register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= 8'h80;
    end else begin
      res_q <= res_d;
    end
  end
  assign res_factor = res_q;
  assign ra_updates_stopped = ra_stop_req && (!setup_q[`PCF_BIT_RAMP_EN] || at_limit);
  logic term_pulse_q;
  assign charge_term_pulse = term_pulse_q;

  // Termination pulse register, high for the cycle after detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_pulse_q <= 1'b0;
    end else begin
      term_pulse_q <= term_now;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_CAL_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    calibration_mode |-> setup_q[`PCF_BIT_CAL_ALLOW]) else $error("Calibration without permission.");
  AST_RAMP: assert property (@(posedge pclk) disable iff (!presetn)
    (ra_updates_stopped && setup_q[`PCF_BIT_RAMP_EN]) |-> res_q == res_factor_limit)
    else $error("Updates stopped before ramp end.");
  AST_RAMP_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    (meas.valid && ra_stop_req && setup_q[`PCF_BIT_RAMP_EN] && !ra_updates_stopped)
    |=> (res_q == $past(res_q) + 8'h01) || (res_q == $past(res_q) - 8'h01))
    else $error("Resistance factor did not step by one.");
  AST_LOAD_CAP: assert property (@(posedge pclk) disable iff (!presetn)
    (term_now && setup_q[`PCF_BIT_FULL_ON_TERM]) |=> left_cap_q == $past(full_cap_q))
    else $error("Left capacity not loaded.");
  AST_TEMP_SRC: assert property (@(posedge pclk) disable iff (!presetn)
    !setup_q[`PCF_BIT_EXT_SENSOR] |-> temp_sel == meas.int_temp) else $error("Wrong sensor.");
  AST_CHG_SET: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flags_q.charge_overheat_flag)
    |-> (cnt_q[0] >= $past(per[0])) && ($past(per[0]) != 16'h0000))
    else $error("Charge overheat set early.");
  AST_CHG_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (release_ok[0] && !set_ok[0]) |=> !flags_q.charge_overheat_flag)
    else $error("Charge overheat not released.");
  AST_DSG_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (set_ok[1]) |=> flags_q.discharge_overheat_flag) else $error("Discharge overheat missed.");
  AST_DSG_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (per[1] == 16'h0000) |-> !set_ok[1]) else $error("Disabled discharge overheat set.");
  AST_DSG_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (release_ok[1] && !set_ok[1]) |=> !flags_q.discharge_overheat_flag)
    else $error("Discharge overheat not released.");
  AST_TERM: assert property (@(posedge pclk) disable iff (!presetn)
    term_now |=> !flags_q.charge_allowed_flag ##0 charge_term_pulse)
    else $error("Termination did not clear charge flag.");

endmodule
`default_nettype wire

// ==== verilog/pcf_params.svh ====
`ifndef PCF_PARAMS_SVH
`define PCF_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PCF_OFS_SETUP 12'h000
`define PCF_OFS_STATUS 12'h004
`define PCF_OFS_CHG_HEAT 12'h008
`define PCF_OFS_DSG_HEAT 12'h00C
`define PCF_OFS_PERSIST 12'h010
`define PCF_OFS_FLOW 12'h014
`define PCF_OFS_TARGET 12'h018
`define PCF_OFS_TERM 12'h01C
`define PCF_OFS_FULL_CAP 12'h020
`define PCF_OFS_LEFT_CAP 12'h024
`define PCF_OFS_CONTROL 12'h028
`define PCF_OFS_TEMP 12'h02C

// ----------------------------------------------------------------------
// Pack setup word field positions
// ----------------------------------------------------------------------
`define PCF_BIT_RESERVE_NOLOAD 15
`define PCF_BIT_CAL_ALLOW 14
`define PCF_BIT_DIVIDER_SEL 11
`define PCF_BIT_WAKE_LEVEL 10
`define PCF_BIT_SENSE_HI 9
`define PCF_BIT_SENSE_LO 8
`define PCF_BIT_TIMES_TEN 7
`define PCF_BIT_RAMP_EN 6
`define PCF_BIT_SLEEP_EN 5
`define PCF_BIT_FULL_ON_TERM 4
`define PCF_BIT_EXT_SENSOR 0
`define PCF_SETUP_WMASK 16'hCFF1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PCF_SETUP_RESET 16'h0171
`define PCF_TARGET_MV_RESET 16'h1068
`define PCF_CHG_HEAT_RESET 32'h0000_0000
`define PCF_DSG_HEAT_RESET 32'h0000_0000
`define PCF_PERSIST_RESET 32'h0000_0000
`define PCF_FLOW_RESET 32'h0000_0000
`define PCF_TERM_RESET 32'h0001_0000

// Capacity gain per check interval must exceed this, in 0.01 mAh units (0.25 mAh).
`define PCF_TERM_CAP_MIN 16'h0019
`define PCF_TERM_GOOD_NEEDED 2'h2

`endif

// ==== verilog/pcf_pkg.sv ====
package pcf_pkg;

  // Measurement update carried from the measurement front end.
  typedef struct packed {
    logic valid;
    logic signed [15:0] int_temp;
    logic signed [15:0] mean_current;
    logic [15:0] stack_volts;
    logic [15:0] cap_delta;
  } pcf_meas_type;

  // Status flags kept by the block.
  typedef struct packed {
    logic charge_overheat_flag;
    logic discharge_overheat_flag;
    logic term_seen;
    logic charge_allowed_flag;
  } pcf_flags_type;

endpackage

// ==== dv/pcf_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Host side bus master model
// ----------------------------------------------------------------------
module pcf_host_model (
  input wire logic pclk, // Bus clock.
  output logic psel, // Select.
  output logic penable, // Access phase.
  output logic pwrite, // Direction.
  output logic [11:0] paddr, // Byte address.
  output logic [31:0] pwdata, // Write data.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr // Error response.
);
  // Idle bus from time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // One transfer: setup cycle, access held until ready, then release.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released write data is inverted so stale values are never mistaken for live ones.
    pwdata <= ~wd;
  endtask
endmodule
`default_nettype wire

// ==== dv/test_pcf_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pcf_params.svh"
module test_pcf_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ra_stop_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic rerr;
  pcf_pkg::pcf_meas_type meas;
  pcf_pkg::pcf_flags_type flags;
  logic signed [15:0] thermistor_sense_pin;
  logic [15:0] ext_ofs;
  logic [7:0] res_factor_limit, res_factor;
  logic ra_updates_stopped, calibration_mode, charge_term_pulse;
  int err_total = 0;
  int total_checks = 0;
  int pulses = 0;

  pcf_host_model pcf_host_model_i (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  pcf_top pcf_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas(meas), .thermistor_sense_pin(thermistor_sense_pin),
    .ra_stop_req(ra_stop_req), .res_factor_limit(res_factor_limit), .res_factor(res_factor),
    .ra_updates_stopped(ra_updates_stopped), .calibration_mode(calibration_mode),
    .charge_term_pulse(charge_term_pulse), .flags(flags));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    pcf_host_model_i.xfer(1'b1, a, d, rdat, rerr);
  endtask

  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] e);
    pcf_host_model_i.xfer(1'b0, a, 32'h0000_0000, rdat, rerr);
    chk(n, e, rdat & m);
  endtask

  // One measurement update; flags are settled once the following edge has passed.
  task automatic upd(input logic [15:0] t, input logic [15:0] c, input logic [15:0] v,
      input logic [15:0] d);
    @(posedge pclk);
    meas <= {1'b1, t, c, v, d};
    thermistor_sense_pin <= t + ext_ofs;
    @(posedge pclk);
    meas.valid <= 1'b0;
    #1;
  endtask

  task automatic summarize;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Free-running bus clock.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Counts termination pulses.
  always @(posedge pclk) begin
    if (charge_term_pulse === 1'b1) pulses <= pulses + 1;
  end

  // Cuts a hang short.
  initial begin
    #(20 * 20000);
    err_total++;
    summarize();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    meas = '0;
    thermistor_sense_pin = 16'h0000;
    ext_ofs = 16'h0000;
    ra_stop_req = 1'b0;
    res_factor_limit = 8'h83;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc("setup", `PCF_OFS_SETUP, 32'h0000_FFFF, 32'h0000_0171);
    rdc("target", `PCF_OFS_TARGET, 32'h0000_FFFF, 32'h0000_1068);
    chk("flags", 32'h1, 32'(flags));
    rdc("unmapped", 12'h030, 32'hFFFF_FFFF, 32'h0000_0000);
    chk("slverr", 32'h1, 32'(rerr));
    wr(`PCF_OFS_SETUP, 32'h0000_FFFF);
    rdc("setup mask", `PCF_OFS_SETUP, 32'hFFFF_FFFF, 32'h0000_CFF1);
    wr(`PCF_OFS_SETUP, 32'h0000_0171);
    wr(`PCF_OFS_CONTROL, 32'h0000_0001);
    #1;
    chk("cal off", 32'h0, 32'(calibration_mode));
    wr(`PCF_OFS_SETUP, 32'h0000_4171);
    #1;
    chk("cal on", 32'h1, 32'(calibration_mode));
    wr(`PCF_OFS_CONTROL, 32'h0000_0000);
    wr(`PCF_OFS_SETUP, 32'h0000_0171);
    ext_ofs = 16'h0100;
    upd(16'h0045, 16'h0000, 16'h0000, 16'h0000);
    rdc("temp ext", `PCF_OFS_TEMP, 32'h0000_FFFF, 32'h0000_0145);
    wr(`PCF_OFS_SETUP, 32'h0000_0170);
    upd(16'h0045, 16'h0000, 16'h0000, 16'h0000);
    rdc("temp int", `PCF_OFS_TEMP, 32'h0000_FFFF, 32'h0000_0045);
    wr(`PCF_OFS_SETUP, 32'h0000_0171);
    ext_ofs = 16'h0000;
    // Overheat thresholds: charge 50/40, discharge 60/30, persist 3/2, flow 10/10.
    wr(`PCF_OFS_CHG_HEAT, 32'h0028_0032);
    wr(`PCF_OFS_DSG_HEAT, 32'h001E_003C);
    wr(`PCF_OFS_PERSIST, 32'h0002_0003);
    wr(`PCF_OFS_FLOW, 32'h000A_000A);
    repeat (2) upd(16'h0032, 16'h0014, 16'h0000, 16'h0000);
    upd(16'h002D, 16'h0014, 16'h0000, 16'h0000);
    repeat (2) upd(16'h0032, 16'h0014, 16'h0000, 16'h0000);
    chk("chg hot restart", 32'h0, 32'(flags.charge_overheat_flag));
    upd(16'h0032, 16'h0014, 16'h0000, 16'h0000);
    chk("chg hot set", 32'h1, 32'(flags.charge_overheat_flag));
    upd(16'h0029, 16'h0014, 16'h0000, 16'h0000);
    chk("chg hot hold", 32'h1, 32'(flags.charge_overheat_flag));
    upd(16'h0028, 16'h0014, 16'h0000, 16'h0000);
    chk("chg hot clear", 32'h0, 32'(flags.charge_overheat_flag));
    repeat (4) upd(16'h0032, 16'h000A, 16'h0000, 16'h0000);
    chk("chg flow edge", 32'h0, 32'(flags.charge_overheat_flag));
    upd(16'h003C, 16'hFFF6, 16'h0000, 16'h0000);
    chk("dsg hot early", 32'h0, 32'(flags.discharge_overheat_flag));
    upd(16'h003C, 16'hFFF6, 16'h0000, 16'h0000);
    chk("dsg hot set", 32'h1, 32'(flags.discharge_overheat_flag));
    upd(16'h001E, 16'hFFF6, 16'h0000, 16'h0000);
    chk("dsg hot clear", 32'h0, 32'(flags.discharge_overheat_flag));
    wr(`PCF_OFS_PERSIST, 32'h0000_0003);
    repeat (4) upd(16'h003C, 16'hFFF6, 16'h0000, 16'h0000);
    chk("dsg disabled", 32'h0, 32'(flags.discharge_overheat_flag));
    wr(`PCF_OFS_PERSIST, 32'h0002_0000);
    repeat (4) upd(16'h0032, 16'h0014, 16'h0000, 16'h0000);
    chk("chg disabled", 32'h0, 32'(flags.charge_overheat_flag));
    // Termination: limit 100, period 1, target 4200 less margin 100, volts 4150.
    wr(`PCF_OFS_TERM, 32'h0001_0064);
    wr(`PCF_OFS_TARGET, 32'h0064_1068);
    wr(`PCF_OFS_FULL_CAP, 32'h0000_04D2);
    wr(`PCF_OFS_LEFT_CAP, 32'h0000_0005);
    repeat (2) upd(16'h0000, 16'h0032, 16'h1036, 16'h0019);
    chk("term gain edge", 32'h1, 32'(flags.charge_allowed_flag));
    repeat (2) upd(16'h0000, 16'h0032, 16'h1036, 16'h001A);
    chk("term cleared", 32'h0, 32'(flags.charge_allowed_flag));
    rdc("left loaded", `PCF_OFS_LEFT_CAP, 32'h0000_FFFF, 32'h0000_04D2);
    chk("term pulses", 32'h1, 32'(pulses));
    rdc("status", `PCF_OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0002);
    upd(16'h0000, 16'hFFF6, 16'h1036, 16'h0000);
    chk("allow again", 32'h1, 32'(flags.charge_allowed_flag));
    wr(`PCF_OFS_SETUP, 32'h0000_0161);
    wr(`PCF_OFS_LEFT_CAP, 32'h0000_0005);
    repeat (2) upd(16'h0000, 16'h0032, 16'h1036, 16'h001A);
    rdc("left kept", `PCF_OFS_LEFT_CAP, 32'h0000_FFFF, 32'h0000_0005);
    wr(`PCF_OFS_SETUP, 32'h0000_0171);
    // Ramp to the factor limit before updates stop.
    ra_stop_req <= 1'b1;
    for (int i = 0; i < 200 && ra_updates_stopped !== 1'b1; i++) begin
      upd(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    end
    chk("ra stopped", 32'h1, 32'(ra_updates_stopped));
    chk("ra factor", 32'h83, 32'(res_factor));
    // Lower limit: the factor must step back down before updates stop again.
    @(posedge pclk);
    res_factor_limit <= 8'h81;
    upd(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    for (int i = 0; i < 200 && ra_updates_stopped !== 1'b1; i++) begin
      upd(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    end
    chk("ra down factor", 32'h81, 32'(res_factor));
    summarize();
  end
endmodule
`default_nettype wire
